// [pkg/camset_pkg.sv]
// package for the camera setting command interpreter
// assumes a byte-wide command stream on the same clock as the interpreter
package camset_pkg;

  // command identifiers, shared by host frames and read replies
  localparam logic [7:0] CAMSET_ID_HEIGHT = 8'hAA;
  localparam logic [7:0] CAMSET_ID_GAIN = 8'h80;
  localparam logic [7:0] CAMSET_ID_OFFSET = 8'h84;

  // descriptor byte layout: read/write flag and data length
  localparam int CAMSET_DESC_FLAG_BIT = 7;
  localparam int CAMSET_DESC_LEN_MSB = 6;
  localparam logic [6:0] CAMSET_DATA_LEN = 7'h02;
  localparam logic CAMSET_FLAG_READ = 1'b1;
  localparam logic CAMSET_FLAG_WRITE = 1'b0;

  // legal ranges, inclusive
  localparam logic [15:0] CAMSET_HEIGHT_MIN = 16'h0001;
  localparam logic [15:0] CAMSET_HEIGHT_MAX = 16'h0410;
  localparam logic [15:0] CAMSET_GAIN_MAX = 16'h03FF;
  localparam logic [15:0] CAMSET_OFFSET_MAX = 16'h00FF;

  // advisory gain floors, binning off and on
  localparam logic [15:0] CAMSET_GAIN_HINT_NOBIN = 16'h00F0;
  localparam logic [15:0] CAMSET_GAIN_HINT_VBIN = 16'h00C0;

  // values after reset
  localparam logic [15:0] CAMSET_HEIGHT_RST = 16'h0410;
  localparam logic [15:0] CAMSET_GAIN_RST = 16'h00F0;
  localparam logic [15:0] CAMSET_OFFSET_RST = 16'h0000;

  // reply length in bytes, last index
  localparam logic [1:0] CAMSET_REPLY_LAST = 2'h3;

  // current settings as one bundle
  typedef struct packed {
    logic [15:0] height;
    logic [15:0] gain;
    logic [15:0] offset;
  } camset_settings_t;

  // one byte on the reply stream
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } camset_byte_t;

  // parser states
  typedef enum logic [4:0] {
    CAMSET_IDLE = 5'b00001,
    CAMSET_DESC = 5'b00010,
    CAMSET_DLO = 5'b00100,
    CAMSET_DHI = 5'b01000,
    CAMSET_REPLY = 5'b10000
  } camset_state_t;

endpackage : camset_pkg

// [hdl/camset_cmd.sv]
// command interpreter for height, gain and offset settings
// assumes framing below it delivers bytes with a start-of-frame mark, same clock
`timescale 1ns/1ps

module camset_cmd (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_sof,
  output logic in_ready,
  output logic out_valid,
  output camset_pkg::camset_byte_t out_byte,
  input wire logic out_ready,
  input wire logic vert_binning,
  output camset_pkg::camset_settings_t settings,
  output logic gain_below_hint
);
  import camset_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // frame handling overview
  // request stream: one byte a cycle, taken while in_valid and in_ready are high
  // a byte with in_sof high is a command identifier and opens a new frame
  // the byte after the identifier is the descriptor
  // descriptor bit 7: read/write flag, 1 for read, 0 for write
  // descriptor bits 6:0: data length, always 2 for these settings
  // a read frame ends with its descriptor; no data bytes follow
  // a write frame carries two data bytes after its descriptor
  // data order on both streams: low byte first, high byte second
  // unknown identifier or wrong length: rest of the frame is skipped
  // bytes without in_sof while idle are skipped as well
  // a new in_sof in mid-frame drops the half-received frame
  //
  // parser states, one-hot
  // idle: waits for a byte with in_sof
  // desc: identifier held, waits for the descriptor
  // dlo: write accepted, waits for the low byte
  // dhi: low byte held, waits for the high byte
  // reply: request stream stopped, reply bytes going out
  //
  // write path
  // the low byte waits in lo_q until the high byte arrives
  // the full value is range-checked on the edge that takes the high byte
  // a legal value lands in its setting on that same edge
  // an illegal value is dropped and the old setting stays
  // writes never produce reply bytes
  //
  // read path
  // the descriptor of a read stops the request stream (in_ready low)
  // the current value is copied to rd_val_q on that edge
  // so nothing can change a reply that is already under way
  // reply bytes: identifier, descriptor, low byte, high byte
  // reply descriptor: flag 0, length 2
  // each reply byte stands until out_valid and out_ready meet
  // out_byte.last marks the fourth byte
  // the request stream opens again after the last byte is taken
  //
  // timing of a read, sink never stalling
  // c0 identifier taken, c1 descriptor taken
  // c2 identifier byte shown, in_ready low
  // c3 descriptor byte, c4 low byte, c5 high byte with last
  // c6 reply over, in_ready high again
  //
  // timing of a write
  // c0 identifier, c1 descriptor, c2 low byte, c3 high byte
  // c4 new setting visible on settings
  //
  // after reset
  // height 1040, gain 240, offset 0
  // in_ready high, no reply pending, gain_below_hint low
  // a frame may start on the first edge after reset is released
  //
  // hazards and limits
  // extra bytes after a read descriptor are held off by in_ready
  // and are then skipped, since they lack in_sof
  // gain_below_hint is advice only; low gains are still accepted
  // gain_below_hint follows settings and vert_binning one cycle late
  // every input is on ref_clk, so no synchroniser is needed

  //////////////////////////////////////////////////////////////////////////////
  // state
  camset_state_t state_q, state_d;
  camset_settings_t set_q, set_d;
  logic [7:0] id_q, id_d;
  logic [7:0] lo_q, lo_d;
  logic [15:0] rd_val_q, rd_val_d;
  logic [1:0] cnt_q, cnt_d;
  logic in_ready_q, in_ready_d;
  logic out_valid_q, out_valid_d;
  camset_byte_t out_q, out_d;
  logic hint_q;

  //////////////////////////////////////////////////////////////////////////////
  // decode
  wire take = in_valid & in_ready_q;
  wire is_height = (id_q == CAMSET_ID_HEIGHT);
  wire is_gain = (id_q == CAMSET_ID_GAIN);
  wire is_offset = (id_q == CAMSET_ID_OFFSET);
  wire id_known = is_height | is_gain | is_offset;
  wire desc_flag = in_data[CAMSET_DESC_FLAG_BIT];
  wire [6:0] desc_len = in_data[CAMSET_DESC_LEN_MSB:0];
  wire desc_ok = id_known & (desc_len == CAMSET_DATA_LEN);
  // assembled write value: first byte low, second byte high
  wire [15:0] wr_val = {in_data, lo_q};
  wire height_ok = (wr_val >= CAMSET_HEIGHT_MIN) & (wr_val <= CAMSET_HEIGHT_MAX);
  wire gain_ok = (wr_val <= CAMSET_GAIN_MAX);
  wire offset_ok = (wr_val <= CAMSET_OFFSET_MAX);
  // write strobes, one per setting, only for values inside their range
  wire hi_take = take & ~in_sof & (state_q == CAMSET_DHI);
  wire wr_height = hi_take & is_height & height_ok;
  wire wr_gain = hi_take & is_gain & gain_ok;
  wire wr_offset = hi_take & is_offset & offset_ok;
  // value returned by a read, captured when the reply starts
  wire [15:0] cur_val = is_height ? set_q.height : (is_gain ? set_q.gain : set_q.offset);
  wire [15:0] hint_floor = vert_binning ? CAMSET_GAIN_HINT_VBIN : CAMSET_GAIN_HINT_NOBIN;
  wire out_fire = out_valid_q & out_ready;
  wire [1:0] cnt_nx = cnt_q + 2'h1;
  // reply byte order: id, descriptor, low, high
  wire [7:0] reply_desc = {CAMSET_FLAG_WRITE, CAMSET_DATA_LEN};
  wire [7:0] reply_sel = (cnt_nx == 2'h1) ? reply_desc :
                         (cnt_nx == 2'h2) ? rd_val_q[7:0] :
                         rd_val_q[15:8];

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    state_d = state_q;
    set_d = set_q;
    id_d = id_q;
    lo_d = lo_q;
    rd_val_d = rd_val_q;
    cnt_d = cnt_q;
    in_ready_d = in_ready_q;
    out_valid_d = out_valid_q;
    out_d = out_q;
    if (state_q == CAMSET_REPLY) begin
      if (out_fire) begin
        if (cnt_q == CAMSET_REPLY_LAST) begin
          // reply done, accept input again
          out_valid_d = 1'b0;
          out_d.last = 1'b0;
          in_ready_d = 1'b1;
          state_d = CAMSET_IDLE;
        end else begin
          cnt_d = cnt_nx;
          out_d.data = reply_sel;
          out_d.last = (cnt_nx == CAMSET_REPLY_LAST);
        end
      end
    end else if (take) begin
      if (in_sof) begin
        // a frame start always resynchronises the parser
        id_d = in_data;
        state_d = CAMSET_DESC;
      end else begin
        case (state_q)
          CAMSET_DESC: begin
            if (!desc_ok) begin
              state_d = CAMSET_IDLE;
            end else if (desc_flag == CAMSET_FLAG_READ) begin
              // read: stop input and send the current value
              rd_val_d = cur_val;
              cnt_d = 2'h0;
              in_ready_d = 1'b0;
              out_valid_d = 1'b1;
              out_d.data = id_q;
              out_d.last = 1'b0;
              state_d = CAMSET_REPLY;
            end else begin
              state_d = CAMSET_DLO;
            end
          end
          CAMSET_DLO: begin
            lo_d = in_data;
            state_d = CAMSET_DHI;
          end
          CAMSET_DHI: begin
            // write without reply; out-of-range values leave the setting alone
            if (wr_height) begin
              set_d.height = wr_val;
            end
            if (wr_gain) begin
              set_d.gain = wr_val;
            end
            if (wr_offset) begin
              set_d.offset = wr_val;
            end
            state_d = CAMSET_IDLE;
          end
          default: begin
            state_d = CAMSET_IDLE;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // settings registers, loaded with the power-up values on reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      set_q <= '{height: CAMSET_HEIGHT_RST, gain: CAMSET_GAIN_RST, offset: CAMSET_OFFSET_RST};
    end else begin
      set_q <= set_d;
    end
  end

  // parser registers: state, identifier and held low byte
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= CAMSET_IDLE;
      id_q <= 8'h00;
      lo_q <= 8'h00;
    end else begin
      state_q <= state_d;
      id_q <= id_d;
      lo_q <= lo_d;
    end
  end

  // reply registers: snapshot, byte count and both handshakes
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_val_q <= 16'h0000;
      cnt_q <= 2'h0;
      in_ready_q <= 1'b1;
      out_valid_q <= 1'b0;
      out_q <= '0;
    end else begin
      rd_val_q <= rd_val_d;
      cnt_q <= cnt_d;
      in_ready_q <= in_ready_d;
      out_valid_q <= out_valid_d;
      out_q <= out_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // advisory flag: gain below the recommended floor for the binning mode
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hint_q <= 1'b0;
    end else begin
      hint_q <= (set_q.gain < hint_floor);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // elaboration checks on the package constants the logic relies on
  generate
    if (CAMSET_HEIGHT_MIN > CAMSET_HEIGHT_MAX) begin : g_bad_height_range
      $error("height range is empty");
    end
    if ((CAMSET_HEIGHT_RST < CAMSET_HEIGHT_MIN) ||
        (CAMSET_HEIGHT_RST > CAMSET_HEIGHT_MAX)) begin : g_bad_height_rst
      $error("height reset value out of range");
    end
    if (CAMSET_GAIN_RST > CAMSET_GAIN_MAX) begin : g_bad_gain_rst
      $error("gain reset value out of range");
    end
    if (CAMSET_OFFSET_RST > CAMSET_OFFSET_MAX) begin : g_bad_offset_rst
      $error("offset reset value out of range");
    end
    if ((CAMSET_DESC_FLAG_BIT != CAMSET_DESC_LEN_MSB + 1) ||
        (CAMSET_DESC_FLAG_BIT != $bits(in_data) - 1)) begin : g_bad_desc
      $error("descriptor fields must fill one byte");
    end
    if (CAMSET_REPLY_LAST != 2'h3) begin : g_bad_reply_len
      $error("reply must be four bytes");
    end
    if (CAMSET_DATA_LEN != 7'h02) begin : g_bad_data_len
      $error("only two data bytes are handled");
    end
    if (CAMSET_GAIN_HINT_NOBIN > CAMSET_GAIN_MAX) begin : g_bad_hint_nobin
      $error("advisory floor above the gain range");
    end
    if (CAMSET_GAIN_HINT_VBIN > CAMSET_GAIN_MAX) begin : g_bad_hint_vbin
      $error("advisory floor above the gain range");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops
  assign in_ready = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_byte = out_q;
  assign settings = set_q;
  assign gain_below_hint = hint_q;

endmodule : camset_cmd

// [dv/camset_monitor.sv]
// checker on the camset_cmd ports
// bound to every camset_cmd below, one clock and one reset
`timescale 1ns/1ps

module camset_monitor import camset_pkg::*; (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic vert_binning,
  input wire logic gain_below_hint,
  input wire camset_byte_t out_byte,
  input wire camset_settings_t settings
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic [1:0] pos_q;
  // byte position inside the current reply
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) pos_q <= 2'h0;
    else if (out_valid && out_ready) pos_q <= pos_q + 2'h1;
  end
  ////////////////////////////////////////////////////////////////
  a_height_range: assert property (settings.height inside {[16'h0001:16'h0410]})
    else $error("height out of range");
  a_gain_range: assert property (settings.gain <= 16'h03FF)
    else $error("gain out of range");
  a_offset_range: assert property (settings.offset[15:8] == 8'h00)
    else $error("offset out of range");
  a_reply_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_byte))
    else $error("reply byte not held");
  a_reply_busy: assert property (out_valid |-> !in_ready)
    else $error("request taken during reply");
  a_reply_ident: assert property (out_valid && pos_q == 2'h0 |->
    out_byte.data inside {8'hAA, 8'h80, 8'h84})
    else $error("bad reply identifier");
  a_reply_desc: assert property (out_valid && pos_q == 2'h1 |-> out_byte.data == 8'h02)
    else $error("bad reply descriptor");
  a_last_pos: assert property (out_valid |-> out_byte.last == (pos_q == 2'h3))
    else $error("last flag misplaced");
  a_last_end: assert property (out_valid && out_ready && out_byte.last |=>
    !out_valid && in_ready)
    else $error("reply did not end");
  a_write_silent: assert property (settings != $past(settings) |-> !out_valid)
    else $error("write answered");
  a_gain_hint: assert property (1'b1 |=> gain_below_hint ==
    ($past(settings.gain) < ($past(vert_binning) ? 16'h00C0 : 16'h00F0)))
    else $error("gain hint wrong");
  c_read: cover property (out_valid && out_byte.last && out_ready);
  c_stall: cover property (out_valid && !out_ready);
  c_write: cover property (settings != $past(settings));
endmodule : camset_monitor

bind camset_cmd camset_monitor i_camset_monitor (.ref_clk, .arst_n, .in_ready, .out_valid,
  .out_ready, .vert_binning, .gain_below_hint, .out_byte, .settings);

// [dv/camset_host.sv]
// host model: sends command frames and drains replies
// assumes camset_cmd on the same clock, inputs changed at the falling edge
`timescale 1ns/1ps

module camset_host import camset_pkg::*; (
  input wire logic ref_clk,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire camset_byte_t out_byte,
  output logic in_valid,
  output logic in_sof,
  output logic out_ready,
  output logic [7:0] in_data
);
  logic slow = 1'b0; // toggle out_ready every cycle, so each reply byte is stalled once
  initial begin
    in_valid = 1'b0;
    in_sof = 1'b0;
    in_data = 8'h00;
    out_ready = 1'b0;
  end
  // offer one byte and hold it until taken
  task put(input logic [7:0] b, input logic s);
    @(negedge ref_clk);
    in_valid = 1'b1;
    in_data = b;
    in_sof = s;
    while (!in_ready) @(negedge ref_clk);
    @(posedge ref_clk);
  endtask : put
  // release the request lines, data shows the inverse
  task idle;
    @(negedge ref_clk);
    in_valid = 1'b0;
    in_sof = 1'b0;
    in_data = ~in_data;
  endtask : idle
  task wr(input logic [7:0] id, input logic [15:0] v);
    put(id, 1'b1);
    put(8'h02, 1'b0);
    put(v[7:0], 1'b0);
    put(v[15:8], 1'b0);
    idle();
  endtask : wr
  // read frame, then collect four reply bytes in order
  task rd(input logic [7:0] id, output logic [31:0] r, output logic [3:0] l);
    int k;
    k = 0;
    put(id, 1'b1);
    put(8'h82, 1'b0);
    idle();
    repeat (100) if (k < 4) begin
      @(negedge ref_clk);
      out_ready = slow ? ~out_ready : 1'b1;
      if (out_valid && out_ready) begin
        r = {r[23:0], out_byte.data};
        l = {l[2:0], out_byte.last};
        k++;
      end
    end
    @(negedge ref_clk);
    out_ready = 1'b0;
  endtask : rd
endmodule : camset_host

// [dv/camset_cmd_tb.sv]
// testbench for camset_cmd driven by the host model
// assumes camset_host and camset_monitor compiled before
`timescale 1ns/1ps

module camset_cmd_tb;
  import camset_pkg::*;
  logic ref_clk = 1'b0, arst_n = 1'b0, vert_binning = 1'b0;
  logic in_valid, in_sof, in_ready, out_valid, out_ready, gain_below_hint;
  logic [7:0] in_data;
  camset_byte_t out_byte;
  camset_settings_t settings;
  int n_errors = 0, n_compared = 0, cyc = 0;
  always #2.5 ref_clk = ~ref_clk;
  camset_cmd i_camset_cmd (.ref_clk, .arst_n, .in_valid, .in_data, .in_sof, .in_ready,
    .out_valid, .out_byte, .out_ready, .vert_binning, .settings, .gain_below_hint);
  camset_host i_camset_host (.ref_clk, .in_ready, .out_valid, .out_byte, .in_valid,
    .in_sof, .out_ready, .in_data);
  ////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [47:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // optional write, then read back and check the whole reply
  task wrd(input logic [7:0] id, input logic [15:0] v, e, input logic w);
    logic [31:0] r;
    logic [3:0] l;
    if (w) i_camset_host.wr(id, v);
    i_camset_host.rd(id, r, l);
    chk("reply id", r[31:24], id);
    chk("reply length", r[23:16], 8'h02);
    chk("value", {r[7:0], r[15:8]}, e);
    chk("last flags", l, 4'b0001);
  endtask : wrd
  // hang guard, a full run needs well under 2000 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (16) @(negedge ref_clk);
    arst_n = 1'b1;
    wrd(8'hAA, 16'h0000, 16'h0410, 1'b0);
    wrd(8'h80, 16'h0000, 16'h00F0, 1'b0);
    wrd(8'h84, 16'h0000, 16'h0000, 1'b0);
    $display("test reset values done");
    wrd(8'hAA, 16'h0001, 16'h0001, 1'b1);
    wrd(8'hAA, 16'h0410, 16'h0410, 1'b1);
    wrd(8'h80, 16'h03FF, 16'h03FF, 1'b1);
    wrd(8'h84, 16'h00FF, 16'h00FF, 1'b1);
    i_camset_host.slow = 1'b1;
    wrd(8'hAA, 16'h0000, 16'h0410, 1'b1);
    wrd(8'hAA, 16'h0411, 16'h0410, 1'b1);
    wrd(8'h80, 16'h0400, 16'h03FF, 1'b1);
    wrd(8'h84, 16'h0100, 16'h00FF, 1'b1);
    $display("test ranges and stalls done");
    // unknown identifier read, then a gain write cut short by a new frame
    i_camset_host.put(8'hAB, 1'b1);
    i_camset_host.put(8'h82, 1'b0);
    i_camset_host.put(8'h80, 1'b1);
    i_camset_host.put(8'h02, 1'b0);
    i_camset_host.put(8'h11, 1'b0);
    // length three frame carrying a legal gain must be dropped
    i_camset_host.put(8'h80, 1'b1);
    i_camset_host.put(8'h03, 1'b0);
    i_camset_host.put(8'h34, 1'b0);
    i_camset_host.put(8'h01, 1'b0);
    i_camset_host.idle();
    repeat (4) @(negedge ref_clk);
    chk("no reply", {out_valid, in_ready}, 2'b01);
    wrd(8'h80, 16'h0000, 16'h03FF, 1'b0);
    wrd(8'h80, 16'h00C8, 16'h00C8, 1'b1);
    chk("hint binning off", gain_below_hint, 1'b1);
    vert_binning = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("hint binning on", gain_below_hint, 1'b0);
    chk("settings", settings, {16'h0410, 16'h00C8, 16'h00FF});
    $display("test framing and hint done");
    report_and_stop();
  end
endmodule : camset_cmd_tb
